/* spd_params.svh */
// Constants for the sample pulse detector and gain/offset register bank
`ifndef SPD_PARAMS_SVH
`define SPD_PARAMS_SVH

// Register indices; byte address is four times the index
`define SPD_IDX_GAIN_UPPER_RED 6'h28
`define SPD_IDX_GAIN_UPPER_GREEN 6'h29
`define SPD_IDX_GAIN_UPPER_BLUE 6'h2a
`define SPD_IDX_GAIN_UPPER_ALL 6'h2b
`define SPD_IDX_EDGE_SETUP 6'h05
`define SPD_IDX_SPEED_BIAS 6'h06
`define SPD_IDX_OFFSET_RED 6'h20
`define SPD_IDX_OFFSET_GREEN 6'h21
`define SPD_IDX_OFFSET_BLUE 6'h22
`define SPD_IDX_OFFSET_ALL 6'h23
`define SPD_IDX_GAIN_LOW_RED 6'h24
`define SPD_IDX_GAIN_LOW_GREEN 6'h25
`define SPD_IDX_GAIN_LOW_BLUE 6'h26
`define SPD_IDX_GAIN_LOW_ALL 6'h27

// Field positions
`define SPD_BIT_DETECT_ENABLE 0
`define SPD_DELAY_LSB 1
`define SPD_DELAY_MSB 3
`define SPD_BIT_POLARITY 4
`define SPD_BIT_FAST_BIAS 1

// Reset values
`define SPD_RST_BYTE 8'h00
`define SPD_RST_DELAY 3'h0
`define SPD_RST_BIT 1'b0

`endif

/* spd_pkg.sv */
// Types shared by the sample pulse detector register bank
package spd_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } spd_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } spd_wb_rsp_t;

    typedef struct packed {
        logic [8:0] red;
        logic [8:0] green;
        logic [8:0] blue;
    } spd_gain_t;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } spd_offset_t;

    typedef enum logic [1:0] {
        SPD_IDLE = 2'b00,
        SPD_COUNT = 2'b01,
        SPD_FIRE = 2'b10
    } spd_det_state_t;

    typedef struct packed {
        spd_wb_rsp_t rsp;
        logic detect_en;
        logic [2:0] delay;
        logic polarity;
        logic fast_bias;
        spd_offset_t offset;
        logic [2:0] gain_low;
        logic [7:0] gain_up_r;
        logic [7:0] gain_up_g;
        logic [7:0] gain_up_b;
        logic pin_prev;
        spd_det_state_t det_state;
        logic [2:0] det_count;
        logic sync_pulse;
        spd_gain_t gain;
    } spd_state_t;

endpackage

/* spd_pulse_model.sv */
// Timing controller model driving the sample pulse pin
`timescale 1ns/10ps
module spd_pulse_model (
    input wire logic mclk,
    input wire logic run,
    input wire logic [4:0] half,
    output logic pin
);
    logic [4:0] cnt_reg;
    initial begin
        pin = 1'b0;
        cnt_reg = 5'h00;
    end
    // Square wave while running; the pin rests low when stopped
    always @(posedge mclk) begin
        if (!run) begin
            pin <= 1'b0;
            cnt_reg <= 5'h00;
        end else if (cnt_reg == half - 5'h01) begin
            pin <= !pin;
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
endmodule

/* spd_regs.sv */
// Sample pulse edge detector with speed, offset and gain registers on Wishbone
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
`include "spd_params.svh"

module spd_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire spd_pkg::spd_wb_req_t wb_req,
    output spd_pkg::spd_wb_rsp_t wb_rsp,
    input wire logic video_sample_pulse_pin,
    output logic timing_sample_pulse,
    output logic fast_bias_select,
    output spd_pkg::spd_offset_t offset_value,
    output spd_pkg::spd_gain_t gain_code
);
    import spd_pkg::*;

    spd_state_t state_reg;
    spd_state_t state_next;

    // Byte lane merge for the low byte; upper lanes hold nothing
    function automatic logic [7:0] lane0(input logic [7:0] old, input spd_wb_req_t r);
        lane0 = r.sel[0] ? r.dat[7:0] : old;
    endfunction

    function automatic logic [31:0] zext8(input logic [7:0] v);
        zext8 = {24'h000000, v};
    endfunction

    logic [5:0] idx;
    logic wr;
    logic rd_go;
    logic edge_seen;
    logic pin_now;

    assign idx = wb_req.adr[7:2];

    always_comb begin
        state_next = state_reg;
        pin_now = video_sample_pulse_pin;
        // Pin taken as synchronous; compare with the previous sample
        edge_seen = state_reg.polarity ? (pin_now & ~state_reg.pin_prev)
                                       : (~pin_now & state_reg.pin_prev);
        rd_go = wb_req.cyc & wb_req.stb & ~state_reg.rsp.ack;
        wr = rd_go & wb_req.we;
        state_next.rsp.ack = rd_go;
        state_next.rsp.dat = 32'h00000000;
        state_next.pin_prev = pin_now;

        if (rd_go & ~wb_req.we) begin
            case (idx)
                `SPD_IDX_EDGE_SETUP: state_next.rsp.dat = zext8({3'h0, state_reg.polarity,
                                                                state_reg.delay, state_reg.detect_en});
                `SPD_IDX_SPEED_BIAS: state_next.rsp.dat = zext8({6'h00, state_reg.fast_bias, 1'b0});
                `SPD_IDX_OFFSET_RED: state_next.rsp.dat = zext8(state_reg.offset.red);
                `SPD_IDX_OFFSET_GREEN: state_next.rsp.dat = zext8(state_reg.offset.green);
                `SPD_IDX_OFFSET_BLUE, `SPD_IDX_OFFSET_ALL: state_next.rsp.dat = zext8(state_reg.offset.blue);
                `SPD_IDX_GAIN_LOW_RED: state_next.rsp.dat = zext8({7'h00, state_reg.gain_low[0]});
                `SPD_IDX_GAIN_LOW_GREEN: state_next.rsp.dat = zext8({7'h00, state_reg.gain_low[1]});
                `SPD_IDX_GAIN_LOW_BLUE, `SPD_IDX_GAIN_LOW_ALL:
                    state_next.rsp.dat = zext8({7'h00, state_reg.gain_low[2]});
                `SPD_IDX_GAIN_UPPER_RED: state_next.rsp.dat = zext8(state_reg.gain_up_r);
                `SPD_IDX_GAIN_UPPER_GREEN: state_next.rsp.dat = zext8(state_reg.gain_up_g);
                `SPD_IDX_GAIN_UPPER_BLUE, `SPD_IDX_GAIN_UPPER_ALL: state_next.rsp.dat = zext8(state_reg.gain_up_b);
                default: state_next.rsp.dat = 32'h00000000;
            endcase
        end

        if (wr) begin
            case (idx)
                `SPD_IDX_EDGE_SETUP: begin
                    // Reserved upper bits are not stored and read back zero
                    if (wb_req.sel[0]) begin
                        state_next.detect_en = wb_req.dat[`SPD_BIT_DETECT_ENABLE];
                        state_next.delay = wb_req.dat[`SPD_DELAY_MSB:`SPD_DELAY_LSB];
                        state_next.polarity = wb_req.dat[`SPD_BIT_POLARITY];
                    end
                end
                `SPD_IDX_SPEED_BIAS: begin
                    if (wb_req.sel[0]) begin
                        state_next.fast_bias = wb_req.dat[`SPD_BIT_FAST_BIAS];
                    end
                end
                `SPD_IDX_OFFSET_RED: state_next.offset.red = lane0(state_reg.offset.red, wb_req);
                `SPD_IDX_OFFSET_GREEN: state_next.offset.green = lane0(state_reg.offset.green, wb_req);
                `SPD_IDX_OFFSET_BLUE: state_next.offset.blue = lane0(state_reg.offset.blue, wb_req);
                `SPD_IDX_OFFSET_ALL: begin
                    if (wb_req.sel[0]) begin
                        state_next.offset = {3{wb_req.dat[7:0]}};
                    end
                end
                `SPD_IDX_GAIN_LOW_RED: begin
                    if (wb_req.sel[0]) begin
                        state_next.gain_low[0] = wb_req.dat[0];
                    end
                end
                `SPD_IDX_GAIN_LOW_GREEN: begin
                    if (wb_req.sel[0]) begin
                        state_next.gain_low[1] = wb_req.dat[0];
                    end
                end
                `SPD_IDX_GAIN_LOW_BLUE: begin
                    if (wb_req.sel[0]) begin
                        state_next.gain_low[2] = wb_req.dat[0];
                    end
                end
                `SPD_IDX_GAIN_LOW_ALL: begin
                    if (wb_req.sel[0]) begin
                        state_next.gain_low = {3{wb_req.dat[0]}};
                    end
                end
                `SPD_IDX_GAIN_UPPER_RED: state_next.gain_up_r = lane0(state_reg.gain_up_r, wb_req);
                `SPD_IDX_GAIN_UPPER_GREEN: state_next.gain_up_g = lane0(state_reg.gain_up_g, wb_req);
                `SPD_IDX_GAIN_UPPER_BLUE: state_next.gain_up_b = lane0(state_reg.gain_up_b, wb_req);
                `SPD_IDX_GAIN_UPPER_ALL: begin
                    if (wb_req.sel[0]) begin
                        state_next.gain_up_r = wb_req.dat[7:0];
                        state_next.gain_up_g = wb_req.dat[7:0];
                        state_next.gain_up_b = wb_req.dat[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Gain outputs follow the stored registers one cycle later
        state_next.gain.red = {state_reg.gain_up_r, state_reg.gain_low[0]};
        state_next.gain.green = {state_reg.gain_up_g, state_reg.gain_low[1]};
        state_next.gain.blue = {state_reg.gain_up_b, state_reg.gain_low[2]};

        // Detector; a new edge during a count is ignored and the count runs on from the first edge
        state_next.sync_pulse = 1'b0;
        if (!state_reg.detect_en) begin
            state_next.det_state = SPD_IDLE;
            state_next.det_count = 3'h0;
            state_next.sync_pulse = pin_now;
        end else begin
            case (state_reg.det_state)
                SPD_IDLE: begin
                    if (edge_seen) begin
                        if (state_reg.delay == 3'h0) begin
                            state_next.sync_pulse = 1'b1;
                        end else begin
                            state_next.det_state = SPD_COUNT;
                            state_next.det_count = state_reg.delay;
                        end
                    end
                end
                SPD_COUNT: begin
                    if (state_reg.det_count == 3'h1) begin
                        state_next.sync_pulse = 1'b1;
                        state_next.det_state = SPD_IDLE;
                    end else begin
                        state_next.det_count = state_reg.det_count - 3'h1;
                    end
                end
                default: state_next.det_state = SPD_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.delay <= `SPD_RST_DELAY;
            state_reg.offset <= {3{`SPD_RST_BYTE}};
            state_reg.det_state <= SPD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_rsp = state_reg.rsp;
    assign timing_sample_pulse = state_reg.sync_pulse;
    assign fast_bias_select = state_reg.fast_bias;
    assign offset_value = state_reg.offset;
    assign gain_code = state_reg.gain;

endmodule

/* spd_regs_assertions.sv */
// Port-level checker for the sample pulse register bank
`timescale 1ns/10ps
module spd_regs_assertions (
    input wire logic mclk,
    input wire logic rst_n,
    input wire spd_pkg::spd_wb_req_t wb_req,
    input wire spd_pkg::spd_wb_rsp_t wb_rsp,
    input wire logic video_sample_pulse_pin,
    input wire logic timing_sample_pulse,
    input wire logic fast_bias_select,
    input wire spd_pkg::spd_offset_t offset_value,
    input wire spd_pkg::spd_gain_t gain_code
);
    import spd_pkg::*;
    logic take_w;
    logic pin_q;
    logic [4:0] setup_reg;
    logic fast_reg;
    logic [3:0] gap_reg;
    assign take_w = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && !wb_rsp.ack;
    // Shadows of the setup bytes and a count of cycles since the selected edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            setup_reg <= 5'h00;
            fast_reg <= 1'b0;
            gap_reg <= 4'hf;
            pin_q <= 1'b0;
        end else begin
            pin_q <= video_sample_pulse_pin;
            if (take_w && wb_req.adr == 8'h14) begin
                setup_reg <= wb_req.dat[4:0];
            end
            if (take_w && wb_req.adr == 8'h18) begin
                fast_reg <= wb_req.dat[1];
            end
            if (video_sample_pulse_pin != pin_q && video_sample_pulse_pin == setup_reg[4]) begin
                gap_reg <= 4'h1;
            end else if (gap_reg != 4'hf) begin
                gap_reg <= gap_reg + 4'h1;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ack_one_cycle: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property ((wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> wb_rsp.ack)
        else $error("request not answered in one cycle");
    a_idle_data_zero: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
        else $error("read data not zero outside ack");
    a_read_upper_zero: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_pin_passthru: assert property (
        (!setup_reg[0] && !$past(setup_reg[0]) && $past(rst_n))
        |-> timing_sample_pulse == $past(video_sample_pulse_pin))
        else $error("pin not passed through with detect off");
    a_pulse_delay: assert property (
        (setup_reg[0] && $past(setup_reg[0]) && timing_sample_pulse) |-> gap_reg == {1'b0, setup_reg[3:1]} + 4'h1)
        else $error("internal pulse at wrong distance from selected edge");
    a_pulse_single: assert property (
        (setup_reg[0] && $past(setup_reg[0]) && timing_sample_pulse) |=> !timing_sample_pulse)
        else $error("internal pulse longer than one cycle");
    a_fast_bias: assert property (fast_bias_select == fast_reg)
        else $error("fast bias output differs from written bit");
    a_offset_all: assert property (
        (wb_rsp.ack && $past(take_w && wb_req.adr == 8'h8c)) |-> offset_value == {3{$past(wb_req.dat[7:0])}})
        else $error("shared offset write did not reach all channels");
endmodule
bind spd_regs spd_regs_assertions chk (.mclk(mclk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .video_sample_pulse_pin(video_sample_pulse_pin), .timing_sample_pulse(timing_sample_pulse),
    .fast_bias_select(fast_bias_select), .offset_value(offset_value), .gain_code(gain_code));

/* tb_spd_regs.sv */
// Testbench for the sample pulse register bank
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_spd_regs;
    import spd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic run = 1'b0;
    logic pin, timing, fast, pv;
    spd_wb_req_t req = '0;
    spd_wb_rsp_t rsp;
    spd_offset_t offs;
    spd_gain_t gain;
    logic [31:0] rd;
    int n_mismatch = 0;
    int check_count = 0;
    int i, d, p, t;
    always #25 mclk = !mclk;
    spd_regs uut (.mclk(mclk), .rst_n(rst_n), .wb_req(req), .wb_rsp(rsp), .video_sample_pulse_pin(pin),
        .timing_sample_pulse(timing), .fast_bias_select(fast), .offset_value(offs), .gain_code(gain));
    spd_pulse_model far (.mclk(mclk), .run(run), .half(5'h0a), .pin(pin));
    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One classic cycle; entered and left just after a rising edge
    task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h0, wd}};
        do begin
            @(posedge mclk);
            k++;
        end while (rsp.ack !== 1'b1 && k < 20);
        rd = rsp.dat;
        req <= '0;
        if (k >= 20) begin
            n_mismatch++;
            complete_run();
        end
        @(posedge mclk);
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK("read", {24'h0, e}, rd)
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        for (i = 0; i < 64; i++) rchk(6'(i), 8'h00);
        for (i = 0; i < 3; i++) bus(1'b1, 6'(32 + i), 8'(17 * (i + 1)));
        `CHK("offset", 24'h112233, offs)
        rchk(6'h21, 8'h22);
        bus(1'b1, 6'h23, 8'h5a);
        `CHK("offset_all", {3{8'h5a}}, offs)
        bus(1'b1, 6'h28, 8'h81);
        bus(1'b1, 6'h29, 8'h42);
        bus(1'b1, 6'h2a, 8'hff);
        bus(1'b1, 6'h24, 8'h01);
        bus(1'b1, 6'h25, 8'h00);
        bus(1'b1, 6'h26, 8'h01);
        @(posedge mclk);
        `CHK("gain", {9'h103, 9'h084, 9'h1ff}, gain)
        bus(1'b1, 6'h27, 8'h00);
        bus(1'b1, 6'h2b, 8'hc3);
        @(posedge mclk);
        `CHK("gain_all", {3{9'h186}}, gain)
        rchk(6'h2a, 8'hc3);
        bus(1'b1, 6'h3f, 8'hff);
        rchk(6'h3f, 8'h00);
        bus(1'b1, 6'h06, 8'h02);
        `CHK("fast", 1'b1, fast)
        rchk(6'h06, 8'h02);
        bus(1'b1, 6'h05, 8'h1e);
        run <= 1'b1;
        pv = pin;
        repeat (40) begin
            @(posedge mclk);
            `CHK("passthru", pv, timing)
            pv = pin;
        end
        // Every polarity and delay; half period 10 keeps edges out of a running count
        for (p = 0; p < 2; p++) begin
            for (d = 0; d < 8; d++) begin
                run <= 1'b0;
                repeat (12) @(posedge mclk);
                bus(1'b1, 6'h05, 8'(p * 16 + d * 2 + 1));
                run <= 1'b1;
                pv = pin;
                t = -1;
                for (i = 0; i < 60; i++) begin
                    @(posedge mclk);
                    if (t >= 0 && timing === 1'b1) break;
                    if (t < 0 && pin !== pv && pin === p[0]) t = i;
                    pv = pin;
                end
                `CHK("delay", d + 1, i - t)
                if (i == 60) begin
                    // A pulse that never came is a failure in its own right
                    n_mismatch++;
                    complete_run();
                end
            end
        end
        complete_run();
    end
endmodule
